// file: core/mon_port_pkg.sv
// Shared constants and types for the monitor serial target port.
`default_nettype none
package mon_port_pkg;
    // Fixed upper five bits of the seven-bit static address.
    localparam logic [4:0] STATIC_ADDR_HI = 5'h10;
    // Address byte layout: seven address bits, then one direction bit.
    localparam int ADDR_BITS = 7;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    // Direction bit value that asks the target to send data.
    localparam logic DIR_READ = 1'b1;
    // Provisional identifier field that carries the select pins.
    localparam int PID_SEL_LSB = 12;
    localparam int PID_SEL_MSB = 15;
    // Arbitrary neutral identifier base; bits 15 to 12 are overwritten.
    localparam logic [47:0] PID_BASE_DEFAULT = 48'h0A5C_3E71_0001;
    // Core clock period, in nanoseconds.
    localparam int MCLK_PERIOD_NS = 4;
    // Longest pulse that is rejected in I2C mode, in nanoseconds.
    localparam int SPIKE_REJECT_WIDTH_NS = 50;
    // Longest rejected pulse in cycles, rounded down.
    localparam int SPIKE_REJECT_CYC = SPIKE_REJECT_WIDTH_NS / MCLK_PERIOD_NS;
    // Samples past the first differing one that a new level must hold; one
    // beyond the rejection width, so a pulse of the full width never wins.
    localparam logic [3:0] FILT_ACCEPT_CNT = 4'(SPIKE_REJECT_CYC + 1);
    // Bus timeout with SCL held low, least value, in milliseconds.
    localparam int BUS_TIMEOUT_MS = 25;
    // Least timeout rounded up to whole cycles.
    localparam int BUS_TIMEOUT_CYC =
        (BUS_TIMEOUT_MS * 1000000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // Cycles after reset release before the select pins are frozen.
    localparam logic [1:0] SEL_SETTLE_CYC = 2'h3;
    // Reset values.
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Bus operating mode.
    typedef enum logic {
        MODE_I2C = 1'b0,
        MODE_I3C = 1'b1
    } bus_mode_t;
endpackage : mon_port_pkg
`default_nettype wire

// file: core/monitor_serial_target_port.sv
// Serial target port: address decode, drive control, filter and timeout.
`default_nettype none
module monitor_serial_target_port #(
    parameter int unsigned TIMEOUT_CYC = mon_port_pkg::BUS_TIMEOUT_CYC,
    parameter bit HAS_STATIC = 1'b1,
    parameter logic [47:0] PID_BASE = mon_port_pkg::PID_BASE_DEFAULT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_select_high_pin,
    input wire logic addr_select_low_pin,
    input wire logic assign_req,
    input wire logic [6:0] assign_addr,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic [6:0] own_addr,
    output logic i3c_mode,
    output logic [47:0] pid,
    output logic frame_busy,
    output logic bus_timeout
);
    // Two-stage synchronisers for SCL and SDA, index 0 is SCL.
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    // Filtered line levels and their stability counters.
    logic [1:0] pin_f_q;
    logic [3:0] stab_q [2];
    // Previous filtered SDA, for START and STOP detection.
    logic sda_prev_q;
    // Mode register; starts in I2C.
    mon_port_pkg::bus_mode_t mode_q;
    // Frame level; doubles as the asynchronous reset of the SCL domain.
    logic frame_q;
    logic restart_q;
    // SCL-low timeout counter.
    logic [31:0] to_cnt_q;
    // Select pin synchroniser, settle counter and frozen value.
    logic [1:0] sel_s1_q;
    logic [1:0] sel_s2_q;
    logic [1:0] sel_q;
    logic [1:0] sel_cnt_q;
    logic sel_lock_q;
    // Assigned address and transmit byte, both quasi-static during frames.
    logic [6:0] dyn_addr_q;
    logic dyn_valid_q;
    logic [7:0] tx_q;
    // Receive toggle synchroniser and edge history.
    logic [2:0] rx_t_q;
    logic rx_valid_q;
    logic [7:0] rx_data_q;
    // SCL-domain state.
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic first_q;
    logic matched_q;
    logic dir_q;
    logic nack_q;
    logic [7:0] rx_byte_q;
    logic rx_tgl_q;
    logic oe_q;
    logic out_q;
    logic start_det;
    logic stop_det;
    logic timeout_hit;
    logic [6:0] static_addr;

    // True when a received seven-bit address names this target.
    function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] own);
        addr_hit = (rx == own);
    endfunction : addr_hit

    // The static address; the pins supply only the two low bits.
    assign static_addr = {mon_port_pkg::STATIC_ADDR_HI, sel_q};

    // Both protocols share the one synchronised pin pair.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
        end else begin
            pin_s1_q <= {sda_in, scl_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Spike filter per line. In I2C mode a new level must hold for more
    // than the rejection width; I3C bypasses it to keep the 12.5 MHz clock.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pin_f_q[gi] <= 1'b1;
                    stab_q[gi] <= 4'h0;
                end else if (mode_q == mon_port_pkg::MODE_I3C) begin
                    pin_f_q[gi] <= pin_s2_q[gi];
                    stab_q[gi] <= 4'h0;
                end else if (pin_s2_q[gi] == pin_f_q[gi]) begin
                    stab_q[gi] <= 4'h0;
                end else if (stab_q[gi] == mon_port_pkg::FILT_ACCEPT_CNT) begin
                    pin_f_q[gi] <= pin_s2_q[gi];
                    stab_q[gi] <= 4'h0;
                end else begin
                    stab_q[gi] <= stab_q[gi] + 4'h1;
                end
            end
        end
    endgenerate

    // Only the controller makes START and STOP; we just watch for them.
    assign start_det = pin_f_q[0] & sda_prev_q & ~pin_f_q[1];
    assign stop_det = pin_f_q[0] & ~sda_prev_q & pin_f_q[1];
    assign timeout_hit = (to_cnt_q == TIMEOUT_CYC - 1);

    // Frame tracking. A START, repeated or not, drops the frame level for
    // one cycle so the SCL-domain logic restarts with a clean byte count.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sda_prev_q <= 1'b1;
            frame_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            sda_prev_q <= pin_f_q[1];
            restart_q <= start_det;
            if (timeout_hit || stop_det) begin
                frame_q <= 1'b0;
            end else if (start_det) begin
                frame_q <= 1'b0;
            end else if (restart_q) begin
                frame_q <= 1'b1;
            end
        end
    end

    // SCL-low timeout counter; it saturates until SCL rises again.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            to_cnt_q <= 32'h0;
        end else if (pin_f_q[0]) begin
            to_cnt_q <= 32'h0;
        end else if (!timeout_hit) begin
            to_cnt_q <= to_cnt_q + 32'h1;
        end
    end

    // Select pins: synchronised, then frozen a few cycles after reset
    // release, well before a controller can address us.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sel_s1_q <= 2'h0;
            sel_s2_q <= 2'h0;
            sel_q <= 2'h0;
            sel_cnt_q <= 2'h0;
            sel_lock_q <= 1'b0;
        end else begin
            sel_s1_q <= {addr_select_high_pin, addr_select_low_pin};
            sel_s2_q <= sel_s1_q;
            if (!sel_lock_q) begin
                sel_q <= sel_s2_q;
                sel_cnt_q <= sel_cnt_q + 2'h1;
                sel_lock_q <= (sel_cnt_q == mon_port_pkg::SEL_SETTLE_CYC - 2'h1);
            end
        end
    end

    // Address assignment. Accepted only between frames, since the SCL side
    // reads these registers without a handshake. A static address wins.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dyn_addr_q <= mon_port_pkg::ADDR_RESET;
            dyn_valid_q <= 1'b0;
            mode_q <= mon_port_pkg::MODE_I2C;
        end else if (assign_req && !frame_q) begin
            dyn_addr_q <= HAS_STATIC ? static_addr : assign_addr;
            dyn_valid_q <= 1'b1;
            mode_q <= mon_port_pkg::MODE_I3C;
        end
    end

    // Transmit byte is captured only outside frames for the same reason.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_q <= mon_port_pkg::BYTE_RESET;
        end else if (!frame_q) begin
            tx_q <= tx_data;
        end
    end

    // Received-byte crossing: a toggle per byte, then a copy of the byte,
    // which stays still for at least one SCL period.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_t_q <= 3'h0;
            rx_valid_q <= 1'b0;
            rx_data_q <= mon_port_pkg::BYTE_RESET;
        end else begin
            rx_t_q <= {rx_t_q[1:0], rx_tgl_q};
            rx_valid_q <= rx_t_q[2] ^ rx_t_q[1];
            if (rx_t_q[2] ^ rx_t_q[1]) begin
                rx_data_q <= rx_byte_q;
            end
        end
    end

    // I2C always answers at the static address; I3C at the assigned one.
    assign own_addr = dyn_valid_q ? dyn_addr_q : static_addr;

    // SCL rising edge: sample SDA, most significant bit first.
    always_ff @(posedge scl_in or negedge frame_q) begin
        if (!frame_q) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 7'h00;
            first_q <= 1'b1;
            matched_q <= 1'b0;
            dir_q <= 1'b0;
            nack_q <= 1'b0;
            rx_byte_q <= 8'h00;
        end else if (bit_cnt_q == mon_port_pkg::ACK_BIT) begin
            bit_cnt_q <= 4'h0;
            first_q <= 1'b0;
            if (dir_q == mon_port_pkg::DIR_READ && sda_in) begin
                nack_q <= 1'b1;
            end
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q <= {shift_q[5:0], sda_in};
            if (bit_cnt_q == mon_port_pkg::LAST_DATA_BIT && first_q) begin
                matched_q <= addr_hit(shift_q, own_addr);
                dir_q <= sda_in;
            end else if (bit_cnt_q == mon_port_pkg::LAST_DATA_BIT && matched_q) begin
                rx_byte_q <= {shift_q, sda_in};
            end
        end
    end

    // Receive toggle lives apart so it survives the frame-level reset.
    always_ff @(posedge scl_in or negedge nrst) begin
        if (!nrst) begin
            rx_tgl_q <= 1'b0;
        end else if (frame_q && bit_cnt_q == mon_port_pkg::LAST_DATA_BIT && !first_q
                     && matched_q && dir_q != mon_port_pkg::DIR_READ) begin
            rx_tgl_q <= ~rx_tgl_q;
        end
    end

    // SCL falling edge: set up the drive for the next bit. Acknowledge is
    // always open-drain; read data is push-pull only once in I3C mode.
    always_ff @(negedge scl_in or negedge frame_q) begin
        if (!frame_q) begin
            oe_q <= 1'b0;
            out_q <= 1'b0;
        end else if (bit_cnt_q == mon_port_pkg::ACK_BIT) begin
            oe_q <= first_q ? matched_q : (matched_q && !dir_q);
            out_q <= 1'b0;
        end else if (matched_q && dir_q && !nack_q && !first_q) begin
            if (mode_q == mon_port_pkg::MODE_I3C) begin
                oe_q <= 1'b1;
                out_q <= tx_q[3'(mon_port_pkg::LAST_DATA_BIT - bit_cnt_q)];
            end else begin
                oe_q <= ~tx_q[3'(mon_port_pkg::LAST_DATA_BIT - bit_cnt_q)];
                out_q <= 1'b0;
            end
        end else begin
            oe_q <= 1'b0;
            out_q <= 1'b0;
        end
    end

    // The port never drives SCL and only ever answers as a target.
    assign sda_o = out_q;
    assign sda_oe = oe_q;
    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign i3c_mode = (mode_q == mon_port_pkg::MODE_I3C);
    assign pid = {PID_BASE[47:16], 2'b00, sel_q, PID_BASE[11:0]};
    assign frame_busy = frame_q;
    assign bus_timeout = timeout_hit;

    // START, then the frame level returns one cycle after the restart.
    sequence s_restart;
        !frame_q ##1 frame_q;
    endsequence

    a_start_opens_frame: assert property (@(posedge mclk) disable iff (!nrst)
        start_det && !stop_det && !timeout_hit |=> s_restart)
        else $error("frame did not restart after start");
    a_timeout_closes_frame: assert property (@(posedge mclk) disable iff (!nrst)
        timeout_hit |=> !frame_q)
        else $error("timeout did not close frame");
    a_i2c_open_drain: assert property (@(posedge mclk) disable iff (!nrst)
        (mode_q == mon_port_pkg::MODE_I2C) |-> !(sda_oe && sda_o))
        else $error("I2C drove SDA high");
    a_sel_frozen: assert property (@(posedge mclk) disable iff (!nrst)
        sel_lock_q |=> $stable(sel_q) && sel_lock_q)
        else $error("select bits changed after lock");
    a_pid_sel_field: assert property (@(posedge mclk) disable iff (!nrst)
        pid[15:12] == {2'b00, sel_q} && pid[47:16] == PID_BASE[47:16])
        else $error("identifier select field wrong");
    a_static_wins: assert property (@(posedge mclk) disable iff (!nrst)
        assign_req && !frame_q && HAS_STATIC |=> own_addr == static_addr && i3c_mode)
        else $error("static address lost precedence");
    a_static_range: assert property (@(posedge mclk) disable iff (!nrst)
        !dyn_valid_q |-> own_addr[6:2] == mon_port_pkg::STATIC_ADDR_HI)
        else $error("static address outside range");
    a_spike_reject: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(pin_f_q[0]) && $past(mode_q) == mon_port_pkg::MODE_I2C
        |-> $past(stab_q[0]) == mon_port_pkg::FILT_ACCEPT_CNT)
        else $error("short pulse passed the filter");
    a_rx_one_pulse: assert property (@(posedge mclk) disable iff (!nrst)
        rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
endmodule : monitor_serial_target_port
`default_nettype wire

// file: tb/bus_ctl_model.sv
// Behavioural bus controller that clocks the link and drives the shared data wire.
`default_nettype none
module bus_ctl_model (
    output logic scl,
    output logic sda,
    input wire logic dev_oe,
    input wire logic dev_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Controller pull-down; with nobody pulling, the pull-up makes the wire high.
    logic pull_low;
    // Stretch of every bit: 1 gives the 80 ns clock, 4 lets I2C levels outlast the filter.
    int unsigned tscale;
    // Wired level of the one data line shared by every protocol.
    assign sda = pull_low ? 1'b0 : (dev_oe ? dev_o : 1'b1);
    // The link clock stands high between frames.
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
        tscale = 4;
    end
    // START holds data low long enough that the target's spike filter accepts it.
    // The clock falls 1 ns off the core grid, so the bit edges after it meet no core edge.
    task automatic start();
        pull_low = 1'b0;
        scl = 1'b1;
        #200 pull_low = 1'b1;
        #201 scl = 1'b0;
    endtask : start
    // One clock of 80 ns times the stretch: data set low, the wire sampled mid-high.
    task automatic bit_cycle(input logic b, output logic r);
        #(10 * tscale) pull_low = ~b;
        #(30 * tscale) scl = 1'b1;
        #(20 * tscale) r = sda;
        #(20 * tscale) scl = 1'b0;
    endtask : bit_cycle
    // Eight bits most significant first, then a released ninth bit for the answer.
    task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], r[i]);
        end
        bit_cycle(1'b1, a);
        ack = ~a;
    endtask : xfer
    // STOP: data rises while the clock is high, then the bus idles.
    task automatic stop();
        #(10 * tscale) pull_low = 1'b1;
        #(30 * tscale) scl = 1'b1;
        #200 pull_low = 1'b0;
        #199;
    endtask : stop
    // A 40 ns low glitch with the clock high, as fast traffic on a mixed bus makes.
    task automatic spike();
        pull_low = 1'b1;
        #40 pull_low = 1'b0;
    endtask : spike
endmodule : bus_ctl_model
`default_nettype wire

// file: tb/monitor_serial_target_port_tb.sv
// Self-checking bench for the monitor serial target port.
`default_nettype none
module monitor_serial_target_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Short timeout so the stuck-clock case stays quick.
    localparam int unsigned TO_CYC = 200;
    logic mclk, nrst, scl, sda, sda_o, sda_oe, sel_hi, sel_lo, assign_req;
    logic rx_valid, i3c_mode, frame_busy, bus_timeout, busy_seen, pp_seen;
    logic [6:0] assign_addr, own_addr;
    logic [7:0] tx_data, rx_data;
    logic [47:0] pid;
    logic [31:0] seed;
    int err_total, checks_done, rxv_cnt;

    monitor_serial_target_port #(.TIMEOUT_CYC(TO_CYC)) u_monitor_serial_target_port (
        .mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_high_pin(sel_hi), .addr_select_low_pin(sel_lo),
        .assign_req(assign_req), .assign_addr(assign_addr), .tx_data(tx_data),
        .rx_data(rx_data), .rx_valid(rx_valid), .own_addr(own_addr), .i3c_mode(i3c_mode),
        .pid(pid), .frame_busy(frame_busy), .bus_timeout(bus_timeout));
    bus_ctl_model u_bus_ctl_model (.scl(scl), .sda(sda), .dev_oe(sda_oe), .dev_o(sda_o));

    // Core clock at 250 MHz.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Random source: a shift register stepped once per draw.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Counts and compares one value; an unknown never matches.
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Watches short pulses and drive types; sampled on the falling edge, clear of
    // both the core's launching edge and every bit edge.
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) rxv_cnt++;
        if (frame_busy === 1'b1) busy_seen = 1'b1;
        if (i3c_mode === 1'b1 && sda_oe === 1'b1 && sda_o === 1'b1) pp_seen = 1'b1;
        if (i3c_mode === 1'b0 && sda_oe === 1'b1) check("i2c_drive_low", 1'b0, sda_o);
    end

    // Reset with the select pins set, then leave the settle time before traffic.
    task automatic reset_dut(input logic [1:0] sel);
        @(negedge mclk);
        nrst = 1'b0;
        sel_hi = sel[1];
        sel_lo = sel[0];
        // I2C traffic is stretched so every level survives the spike filter.
        u_bus_ctl_model.tscale = 4;
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        repeat (12) @(negedge mclk);
    endtask : reset_dut

    // One complete frame: address byte, one data byte, STOP.
    task automatic frame(input logic [6:0] a, input logic dir, input logic [7:0] d,
                         output logic ack, output logic [7:0] r);
        logic [7:0] junk;
        logic dack;
        u_bus_ctl_model.start();
        u_bus_ctl_model.xfer({a, dir}, junk, ack);
        u_bus_ctl_model.xfer(d, r, dack);
        u_bus_ctl_model.stop();
        repeat (20) @(negedge mclk);
    endtask : frame

    // Cuts a hang short.
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        logic ack;
        logic [7:0] d, r;
        logic [6:0] ea, bad;
        int n;
        nrst = 1'b0;
        sel_hi = 1'b0;
        sel_lo = 1'b0;
        assign_req = 1'b0;
        assign_addr = 7'h00;
        tx_data = 8'h00;
        seed = 32'h6785CB91;
        // Every pin setting, each ending with an assignment and a push-pull read.
        for (int s = 0; s < 4; s++) begin
            reset_dut(s[1:0]);
            ea = {mon_port_pkg::STATIC_ADDR_HI, s[1:0]};
            check("own_addr", ea, own_addr);
            check("pid_sel", {2'b00, s[1:0]}, pid[15:12]);
            check("mode", mon_port_pkg::MODE_I2C, i3c_mode);
            busy_seen = 1'b0;
            u_bus_ctl_model.spike();
            repeat (40) @(negedge mclk);
            check("spike_busy", 1'b0, busy_seen);
            seed = lfsr(seed);
            d = seed[7:0];
            n = rxv_cnt;
            frame(ea, 1'b0, d, ack, r);
            check("wr_ack", 1'b1, ack);
            check("rx_data", d, rx_data);
            check("rx_pulses", n + 1, rxv_cnt);
            // A single wrong address bit must be ignored whole.
            bad = ea ^ (7'h01 << (seed[10:8] % 7));
            frame(bad, 1'b0, ~d, ack, r);
            check("bad_ack", 1'b0, ack);
            check("bad_data", d, rx_data);
            tx_data = seed[15:8] | 8'h80;
            frame(ea, mon_port_pkg::DIR_READ, 8'hFF, ack, r);
            check("rd_ack", 1'b1, ack);
            check("rd_data", tx_data, r);
            sel_hi = ~sel_hi;
            sel_lo = ~sel_lo;
            repeat (10) @(negedge mclk);
            check("addr_frozen", ea, own_addr);
            assign_req = 1'b1;
            assign_addr = seed[22:16];
            @(negedge mclk);
            assign_req = 1'b0;
            check("assigned", ea, own_addr);
            check("mode_i3c", mon_port_pkg::MODE_I3C, i3c_mode);
            u_bus_ctl_model.tscale = 1; // The filter is bypassed, so the 80 ns clock is used.
            pp_seen = 1'b0;
            frame(ea, mon_port_pkg::DIR_READ, 8'hFF, ack, r);
            check("i3c_data", tx_data, r);
            check("push_pull", 1'b1, pp_seen);
        end
        // Clock parked low inside a frame until the interface gives up.
        u_bus_ctl_model.start();
        n = 0;
        while (bus_timeout !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        if (n == 400) begin
            err_total++;
            complete_run();
        end
        check("timeout_time", 1'b1, n >= TO_CYC - 5 && n <= TO_CYC + 20);
        // The frame level drops on the core edge after the timeout is flagged.
        @(negedge mclk);
        check("timeout_busy", 1'b0, frame_busy);
        u_bus_ctl_model.stop();
        complete_run();
    end
endmodule : monitor_serial_target_port_tb
`default_nettype wire
